// ===== hdl/tpd_device.sv
// device end: mode selection, phase decoding, wake sequencing and fault pin
`timescale 1ns/1ps
module tpd_device
    import tpd_pkg::*;
#(
    parameter bit STRAPPED = 1'b1,
    parameter int READY_CYC = READY_CYCLES,
    parameter int WAKE_CYC = WAKE_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    tpd_if.device link,
    input wire logic [PHASES-1:0] gen_high,
    input wire logic [PHASES-1:0] gen_low,
    input wire logic [FAULT_W-1:0] fault_events,
    output logic [PHASES-1:0] high_switch_on,
    output logic [PHASES-1:0] low_switch_on,
    output logic [2*PHASES-1:0] phase_output,
    output tpd_mode_type active_mode,
    output logic awake,
    output logic serial_ready,
    output logic [FAULT_W-1:0] fault_status
);
    logic [31:0] wake_cnt_q;
    logic [31:0] wake_cnt_d;
    logic awake_q;
    logic awake_d;
    logic [1:0] strap_q;
    logic [1:0] strap_d;
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    logic [31:0] ready_cnt_q;
    logic [31:0] ready_cnt_d;
    logic ready_q;
    logic ready_d;
    logic [PHASES-1:0] hs_q;
    logic [PHASES-1:0] hs_d;
    logic [PHASES-1:0] ls_q;
    logic [PHASES-1:0] ls_d;
    logic [2*PHASES-1:0] ph_q;
    logic [2*PHASES-1:0] ph_d;
    logic [FAULT_W-1:0] flt_q;
    logic [FAULT_W-1:0] flt_d;
    logic flt_oe_n_q;
    logic flt_oe_n_d;
    tpd_mode_type mode;

    // wake interval and strap capture
    always_comb
    begin
        wake_cnt_d = wake_cnt_q;
        awake_d = awake_q;
        strap_d = strap_q;
        if (!link.sleep_bar_input)
        begin
            wake_cnt_d = 32'h0000_0000;
            awake_d = 1'b0;
        end
        else if (!awake_q)
        begin
            wake_cnt_d = wake_cnt_q + 32'h0000_0001;
            if (wake_cnt_q == 32'(WAKE_CYC - 1))
            begin
                awake_d = 1'b1;
                // the strap is sampled once per wake, so changes while awake are ignored
                strap_d = link.mode_strap;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wake_cnt_q <= 32'h0000_0000;
            awake_q <= 1'b0;
            strap_q <= STRAP_GND;
        end
        else
        begin
            wake_cnt_q <= wake_cnt_d;
            awake_q <= awake_d;
            strap_q <= strap_d;
        end
    end

    // serial port readiness and mode select field
    always_comb
    begin
        ready_cnt_d = ready_cnt_q;
        ready_d = ready_q;
        sel_d = sel_q;
        if (!ready_q)
        begin
            ready_cnt_d = ready_cnt_q + 32'h0000_0001;
            if (ready_cnt_q == 32'(READY_CYC - 1))
            begin
                ready_d = 1'b1;
            end
        end
        // writes before readiness are dropped; the controller is expected to wait
        if (!STRAPPED && ready_q && link.cfg_mode_write && !link.serial_select_bar)
        begin
            sel_d = link.cfg_mode_value;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ready_cnt_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            sel_q <= SEL_RESET;
        end
        else
        begin
            ready_cnt_q <= ready_cnt_d;
            ready_q <= ready_d;
            sel_q <= sel_d;
        end
    end

    assign mode = STRAPPED ? tpd_mode_from_strap(strap_q) : tpd_mode_from_select(sel_q);

    // per-phase decode
    always_comb
    begin
        tpd_phase_type st;
        st = PH_HIZ;
        hs_d = '0;
        ls_d = '0;
        ph_d = '0;
        for (int i = 0; i < PHASES; i++)
        begin
            st = PH_HIZ;
            if (awake_q)
            begin
                case (mode)
                    MODE_6IN:
                    begin
                        // both high is treated as hi-z, never as shoot-through
                        if (link.phase_high_side_input[i] && !link.phase_low_side_input[i])
                        begin
                            st = PH_HIGH;
                        end
                        else if (!link.phase_high_side_input[i] && link.phase_low_side_input[i])
                        begin
                            st = PH_LOW;
                        end
                    end
                    MODE_3IN:
                    begin
                        if (link.phase_low_side_input[i])
                        begin
                            st = link.phase_high_side_input[i] ? PH_HIGH : PH_LOW;
                        end
                    end
                    MODE_GEN:
                    begin
                        if (gen_high[i] != gen_low[i])
                        begin
                            st = gen_high[i] ? PH_HIGH : PH_LOW;
                        end
                    end
                    default:
                    begin
                        st = PH_HIZ;
                    end
                endcase
            end
            // one state per phase, so at most one switch can be on
            hs_d[i] = (st == PH_HIGH);
            ls_d[i] = (st == PH_LOW);
            ph_d[2*i +: 2] = st;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hs_q <= '0;
            ls_q <= '0;
            ph_q <= '0;
        end
        else
        begin
            hs_q <= hs_d;
            ls_q <= ls_d;
            ph_q <= ph_d;
        end
    end

    // fault pin and detailed fault status
    always_comb
    begin
        flt_d = fault_events;
        flt_oe_n_d = !(|fault_events);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flt_q <= FAULT_RESET;
            flt_oe_n_q <= 1'b1;
        end
        else
        begin
            flt_q <= flt_d;
            flt_oe_n_q <= flt_oe_n_d;
        end
    end

    assign link.fault_flag_bar_out = 1'b0;
    assign link.fault_flag_bar_oe_n = flt_oe_n_q;
    assign high_switch_on = hs_q;
    assign low_switch_on = ls_q;
    assign phase_output = ph_q;
    assign active_mode = mode;
    assign awake = awake_q;
    assign serial_ready = ready_q;
    assign fault_status = STRAPPED ? FAULT_RESET : flt_q;
endmodule

// ===== hdl/tpd_host.sv
// controller end: power-up wait, mode change sequencing and phase drive
`timescale 1ns/1ps
module tpd_host
    import tpd_pkg::*;
#(
    parameter bit STRAPPED = 1'b1,
    parameter bit HIZ_NEEDED = 1'b1,
    parameter int READY_CYC = READY_CYCLES,
    parameter int WAKE_CYC = WAKE_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    tpd_if.host link,
    input wire logic [PHASES-1:0] user_high,
    input wire logic [PHASES-1:0] user_low,
    input wire logic mode_req,
    input wire logic [1:0] mode_req_value,
    output logic ready,
    output logic fault_seen
);
    typedef enum logic [2:0] {H_POWERUP, H_RUN, H_QUIESCE, H_GAP, H_FRAME, H_SLEEP, H_WAKE}
        tpd_hstate_type;
    localparam int POWERUP_CYC = (READY_CYC > WAKE_CYC) ? READY_CYC : WAKE_CYC;

    tpd_hstate_type st_q;
    tpd_hstate_type st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [1:0] val_q;
    logic [1:0] val_d;
    logic [1:0] strap_q;
    logic [1:0] strap_d;
    tpd_mode_type mode_q;
    tpd_mode_type mode_d;
    logic [PHASES-1:0] hs_q;
    logic [PHASES-1:0] hs_d;
    logic [PHASES-1:0] ls_q;
    logic [PHASES-1:0] ls_d;
    logic sel_q;
    logic sel_d;
    logic wr_q;
    logic wr_d;
    logic slp_q;
    logic slp_d;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q + 32'h0000_0001;
        val_d = val_q;
        strap_d = strap_q;
        mode_d = mode_q;
        hs_d = '0;
        ls_d = '0;
        sel_d = 1'b1;
        wr_d = 1'b0;
        slp_d = 1'b1;
        case (st_q)
            H_POWERUP:
            begin
                // no mode change and no frame before both intervals expire
                if (cnt_q == 32'(POWERUP_CYC))
                begin
                    st_d = H_RUN;
                end
            end
            H_RUN:
            begin
                hs_d = user_high;
                ls_d = (mode_q == MODE_3IN && !HIZ_NEEDED) ? '1 : user_low;
                cnt_d = 32'h0000_0000;
                if (mode_req)
                begin
                    val_d = mode_req_value;
                    st_d = STRAPPED ? H_SLEEP : H_QUIESCE;
                    hs_d = '0;
                    ls_d = '0;
                end
            end
            H_QUIESCE:
            begin
                // phase inputs already low here and through the frame
                st_d = H_GAP;
                cnt_d = 32'h0000_0000;
            end
            H_GAP:
            begin
                if (cnt_q == 32'(SEL_GAP_CYCLES - 1))
                begin
                    st_d = H_FRAME;
                    cnt_d = 32'h0000_0000;
                    sel_d = 1'b0;
                end
            end
            H_FRAME:
            begin
                sel_d = 1'b0;
                if (cnt_q == 32'(FRAME_CYCLES - 2))
                begin
                    wr_d = 1'b1;
                end
                if (cnt_q == 32'(FRAME_CYCLES - 1))
                begin
                    sel_d = 1'b1;
                    mode_d = tpd_mode_from_select(val_q);
                    // the trailing select-high gap is timed in the wake state
                    st_d = H_WAKE;
                    cnt_d = 32'h0000_0000;
                end
            end
            H_SLEEP:
            begin
                slp_d = 1'b0;
                // strap moves only once sleep already stands low at the pin
                if (cnt_q != 32'h0000_0000)
                begin
                    strap_d = val_q;
                end
                if (cnt_q == 32'(SLEEP_HOLD_CYCLES))
                begin
                    slp_d = 1'b1;
                    mode_d = tpd_mode_from_strap(val_q);
                    st_d = H_WAKE;
                    cnt_d = 32'h0000_0000;
                end
            end
            H_WAKE:
            begin
                if (cnt_q == 32'(STRAPPED ? WAKE_CYC : SEL_GAP_CYCLES))
                begin
                    st_d = H_RUN;
                end
            end
            default:
            begin
                st_d = H_POWERUP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= H_POWERUP;
            cnt_q <= 32'h0000_0000;
            val_q <= SEL_RESET;
            strap_q <= STRAP_GND;
            mode_q <= MODE_6IN;
            hs_q <= '0;
            ls_q <= '0;
            sel_q <= 1'b1;
            wr_q <= 1'b0;
            slp_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            val_q <= val_d;
            strap_q <= strap_d;
            mode_q <= mode_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
            sel_q <= sel_d;
            wr_q <= wr_d;
            slp_q <= slp_d;
        end
    end

    assign link.phase_high_side_input = hs_q;
    assign link.phase_low_side_input = ls_q;
    assign link.sleep_bar_input = slp_q;
    assign link.mode_strap = strap_q;
    assign link.serial_select_bar = sel_q;
    assign link.cfg_mode_value = val_q;
    assign link.cfg_mode_write = wr_q;
    assign ready = (st_q == H_RUN);
    assign fault_seen = !link.fault_flag_bar;
endmodule

// ===== hdl/tpd_if.sv
// link between the phase decoder and its controller
`timescale 1ns/1ps
interface tpd_if;
    logic [2:0] phase_high_side_input;
    logic [2:0] phase_low_side_input;
    logic sleep_bar_input;
    logic [1:0] mode_strap;
    logic serial_select_bar;
    logic [1:0] cfg_mode_value;
    logic cfg_mode_write;
    logic fault_flag_bar_out;
    logic fault_flag_bar_oe_n;
    logic fault_flag_bar;

    // open-drain with pull-up: released pin reads high
    assign fault_flag_bar = fault_flag_bar_oe_n ? 1'b1 : fault_flag_bar_out;

    modport device (
        input phase_high_side_input,
        input phase_low_side_input,
        input sleep_bar_input,
        input mode_strap,
        input serial_select_bar,
        input cfg_mode_value,
        input cfg_mode_write,
        output fault_flag_bar_out,
        output fault_flag_bar_oe_n
    );
    modport host (
        output phase_high_side_input,
        output phase_low_side_input,
        output sleep_bar_input,
        output mode_strap,
        output serial_select_bar,
        output cfg_mode_value,
        output cfg_mode_write,
        input fault_flag_bar
    );
endinterface

// ===== hdl/tpd_pkg.sv
// shared constants, types and decode functions of the three-phase pwm input decoder
package tpd_pkg;
    localparam int PHASES = 3;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_MHZ = 40;
    localparam logic [1:0] SEL_6IN_A = 2'h0;
    localparam logic [1:0] SEL_6IN_B = 2'h1;
    localparam logic [1:0] SEL_3IN = 2'h2;
    localparam logic [1:0] SEL_GEN = 2'h3;
    localparam logic [1:0] SEL_RESET = SEL_6IN_A;
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_RES_GND = 2'h1;
    localparam logic [1:0] STRAP_RAIL = 2'h2;
    localparam logic [1:0] STRAP_FLOAT = 2'h3;
    localparam int READY_TIME_MS = 1;
    localparam int READY_CYCLES = READY_TIME_MS * (CLK_HZ / 1000);
    localparam int SEL_GAP_NS = 300;
    localparam int SEL_GAP_CYCLES = (SEL_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYCLES = 400;
    localparam int FRAME_CYCLES = 16;
    localparam int SLEEP_HOLD_CYCLES = 2;
    localparam int FAULT_W = 6;
    localparam int FLT_SUPPLY_UNDERVOLTAGE_LOCKOUT = 0;
    localparam int FLT_CHARGE_PUMP_UNDERVOLTAGE = 1;
    localparam int FLT_OCP = 2;
    localparam int FLT_REG_UV = 3;
    localparam int FLT_OTW = 4;
    localparam int FLT_OVERTEMPERATURE_SHUTDOWN = 5;
    localparam logic [FAULT_W-1:0] FAULT_RESET = 6'h00;

    typedef enum logic [1:0] {MODE_6IN, MODE_3IN, MODE_GEN} tpd_mode_type;
    typedef enum logic [1:0] {PH_HIZ, PH_LOW, PH_HIGH} tpd_phase_type;

    function automatic tpd_mode_type tpd_mode_from_select(input logic [1:0] sel);
        case (sel)
            SEL_6IN_A, SEL_6IN_B: return MODE_6IN;
            SEL_3IN: return MODE_3IN;
            default: return MODE_GEN;
        endcase
    endfunction

    function automatic tpd_mode_type tpd_mode_from_strap(input logic [1:0] strap);
        case (strap)
            STRAP_GND, STRAP_RES_GND: return MODE_6IN;
            default: return MODE_3IN;
        endcase
    endfunction
endpackage

// ===== tb/three_phase_pwm_input_decoder_bench.sv
// self-checking bench: controller and decoder joined over the link
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 8'(e), 8'(g))
module three_phase_pwm_input_decoder_bench;
    import tpd_pkg::*;
    // short counts keep the run brief; both ends must agree on them
    localparam int RDY = 50;
    localparam int WK = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] user_high = 3'h0;
    logic [2:0] user_low = 3'h0;
    logic [2:0] gen_high = 3'h0;
    logic [2:0] gen_low = 3'h0;
    logic [5:0] fault_events = 6'h00;
    logic mode_req = 1'b0;
    logic [1:0] mode_req_value = 2'h0;
    logic ready;
    logic fault_seen;
    logic [2:0] high_switch_on;
    logic [2:0] low_switch_on;
    logic [5:0] phase_output;
    tpd_mode_type active_mode;
    logic awake;
    logic serial_ready;
    logic [5:0] fault_status;
    logic s_mode_req = 1'b0;
    logic s_ready;
    logic s_fault_seen;
    logic [5:0] s_phase;
    tpd_mode_type s_mode;
    logic s_awake;
    logic [5:0] s_status;
    int n_errors = 0;
    int checks = 0;
    int seed = 24106;
    logic [1:0] sel_list [4] = '{2'h1, 2'h2, 2'h3, 2'h0};

    tpd_if link ();
    tpd_if s_link ();

    always #12.5 clk = ~clk;

    tpd_device #(.STRAPPED(1'b0), .READY_CYC(RDY), .WAKE_CYC(WK)) i_tpd_device (
        .clk(clk), .nrst(nrst), .link(link), .gen_high(gen_high), .gen_low(gen_low),
        .fault_events(fault_events), .high_switch_on(high_switch_on),
        .low_switch_on(low_switch_on), .phase_output(phase_output),
        .active_mode(active_mode), .awake(awake), .serial_ready(serial_ready),
        .fault_status(fault_status));
    tpd_host #(.STRAPPED(1'b0), .HIZ_NEEDED(1'b1), .READY_CYC(RDY), .WAKE_CYC(WK)) i_tpd_host (
        .clk(clk), .nrst(nrst), .link(link), .user_high(user_high), .user_low(user_low),
        .mode_req(mode_req), .mode_req_value(mode_req_value), .ready(ready),
        .fault_seen(fault_seen));
    tpd_properties #(.READY_CYC(RDY)) i_tpd_properties (
        .clk(clk), .nrst(nrst), .phase_high_side_input(link.phase_high_side_input),
        .phase_low_side_input(link.phase_low_side_input),
        .serial_select_bar(link.serial_select_bar), .cfg_mode_value(link.cfg_mode_value),
        .cfg_mode_write(link.cfg_mode_write), .fault_flag_bar(link.fault_flag_bar),
        .fault_events(fault_events), .high_switch_on(high_switch_on),
        .low_switch_on(low_switch_on), .active_mode(active_mode), .awake(awake));

    // strapped pair; hi-z unused, so its host holds low-side inputs high in three-input mode
    if (1)
    begin : g_strap
        tpd_device #(.STRAPPED(1'b1), .READY_CYC(RDY), .WAKE_CYC(WK)) i_tpd_device (
            .clk(clk), .nrst(nrst), .link(s_link), .gen_high(gen_high), .gen_low(gen_low),
            .fault_events(fault_events), .high_switch_on(), .low_switch_on(),
            .phase_output(s_phase), .active_mode(s_mode), .awake(s_awake),
            .serial_ready(), .fault_status(s_status));
        tpd_host #(.STRAPPED(1'b1), .HIZ_NEEDED(1'b0), .READY_CYC(RDY), .WAKE_CYC(WK))
            i_tpd_host (
            .clk(clk), .nrst(nrst), .link(s_link), .user_high(user_high), .user_low(user_low),
            .mode_req(s_mode_req), .mode_req_value(mode_req_value), .ready(s_ready),
            .fault_seen(s_fault_seen));
    end

    function automatic logic [1:0] exp_phase(tpd_mode_type m, logic h, logic l);
        if (m == MODE_3IN)
            return !l ? 2'h0 : (h ? 2'h2 : 2'h1);
        return (h == l) ? 2'h0 : (h ? 2'h2 : 2'h1);
    endfunction

    function automatic tpd_mode_type exp_mode(logic [1:0] s);
        return s == 2'h3 ? MODE_GEN : (s == 2'h2 ? MODE_3IN : MODE_6IN);
    endfunction

    // rail and floating straps give three-input, both ground straps six-input
    function automatic tpd_mode_type exp_strap(logic [1:0] s);
        return s[1] ? MODE_3IN : MODE_6IN;
    endfunction

    task automatic check(string n, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask

    task automatic results();
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_ready(bit strap, logic v);
        int i;
        for (i = 0; i < 400 && (strap ? s_ready : ready) !== v; i++)
            @(negedge clk);
        if ((strap ? s_ready : ready) !== v)
        begin
            n_errors++;
            results();
        end
    endtask

    // one-cycle pulse, then one idle edge so a following call never re-raises it at once
    task automatic request(bit strap, logic [1:0] v);
        mode_req = !strap;
        s_mode_req = strap;
        mode_req_value = v;
        @(negedge clk);
        mode_req = 1'b0;
        s_mode_req = 1'b0;
        @(negedge clk);
    endtask

    task automatic apply(tpd_mode_type m, tpd_mode_type sm, logic [2:0] h, logic [2:0] l);
        int p;
        logic [2:0] lo;
        lo = l | {3{sm == MODE_3IN}};
        user_high = h;
        user_low = l;
        gen_high = h;
        gen_low = l;
        repeat (3) @(negedge clk);
        for (p = 0; p < 3; p++)
        begin
            `CHK("phase_output", exp_phase(m, h[p], l[p]), phase_output[2*p+:2]);
            `CHK("strap_phase_output", exp_phase(sm, h[p], lo[p]), s_phase[2*p+:2]);
        end
    endtask

    initial
    begin
        int k;
        int j;
        int s;
        tpd_mode_type m;
        tpd_mode_type sm;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        wait_ready(1'b0, 1'b1);
        wait_ready(1'b1, 1'b1);
        `CHK("serial_ready", 1'b1, serial_ready);
        `CHK("active_mode", MODE_6IN, active_mode);
        `CHK("strap_mode", MODE_6IN, s_mode);
        m = MODE_6IN;
        sm = MODE_6IN;
        // the serial pair walks all select codes first, then the strapped pair all strap codes
        for (s = 0; s < 2; s++)
        begin
            for (k = 0; k < 4; k++)
            begin
                request(s[0], sel_list[k]);
                wait_ready(s[0], 1'b0);
                // a request while busy must be dropped
                request(s[0], ~sel_list[k]);
                if (s == 1)
                begin
                    // asleep now, and the new strap must not be taken before the wake ends
                    `CHK("strap_awake", 1'b0, s_awake);
                    `CHK("strap_mode", sm, s_mode);
                end
                wait_ready(s[0], 1'b1);
                if (s == 0)
                    m = exp_mode(sel_list[k]);
                else
                    sm = exp_strap(sel_list[k]);
                `CHK("active_mode", m, active_mode);
                `CHK("strap_mode", sm, s_mode);
                for (j = 0; j < 20; j++)
                begin
                    if (j < 4)
                        apply(m, sm, {3{j[0]}}, {3{j[1]}});
                    else
                        apply(m, sm, 3'($random(seed)), 3'($random(seed)));
                end
            end
        end
        for (k = 0; k < 6; k++)
        begin
            fault_events = 6'h01 << k;
            repeat (2) @(negedge clk);
            `CHK("fault_seen", 1'b1, fault_seen);
            `CHK("fault_status", fault_events, fault_status);
            `CHK("strap_fault_seen", 1'b1, s_fault_seen);
            `CHK("strap_fault_status", 6'h00, s_status);
            fault_events = 6'h00;
            repeat (2) @(negedge clk);
            `CHK("fault_seen", 1'b0, fault_seen);
            `CHK("strap_fault_seen", 1'b0, s_fault_seen);
        end
        results();
    end
endmodule

// ===== tb/tpd_properties.sv
// concurrent checks on the link between the phase decoder and its controller
`timescale 1ns/1ps
module tpd_properties
    import tpd_pkg::*;
#(
    parameter int READY_CYC = READY_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] phase_high_side_input,
    input wire logic [2:0] phase_low_side_input,
    input wire logic serial_select_bar,
    input wire logic [1:0] cfg_mode_value,
    input wire logic cfg_mode_write,
    input wire logic fault_flag_bar,
    input wire logic [FAULT_W-1:0] fault_events,
    input wire logic [PHASES-1:0] high_switch_on,
    input wire logic [PHASES-1:0] low_switch_on,
    input wire tpd_mode_type active_mode,
    input wire logic awake
);
    logic [31:0] up_q;
    logic [31:0] up_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // saturating, so a long run cannot wrap back below the ready time
    always_comb
    begin
        up_d = (up_q < READY_CYC) ? up_q + 32'h1 : up_q;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            up_q <= 32'h0;
        else
            up_q <= up_d;
    end

    no_shoot_through_a: assert property (!(high_switch_on & low_switch_on))
        else $error("both switches of one phase on");
    six_input_decode_a: assert property ($past(awake) && awake &&
        $past(active_mode) == MODE_6IN && active_mode == MODE_6IN |->
        high_switch_on == $past(phase_high_side_input & ~phase_low_side_input) &&
        low_switch_on == $past(phase_low_side_input & ~phase_high_side_input))
        else $error("six-input decode wrong");
    three_input_decode_a: assert property ($past(awake) && awake &&
        $past(active_mode) == MODE_3IN && active_mode == MODE_3IN |->
        high_switch_on == $past(phase_high_side_input & phase_low_side_input) &&
        low_switch_on == $past(~phase_high_side_input & phase_low_side_input))
        else $error("three-input decode wrong");
    asleep_all_off_a: assert property (!$past(awake) && !awake |->
        high_switch_on == 3'h0 && low_switch_on == 3'h0)
        else $error("switch on while asleep");
    fault_pin_a: assert property (1'b1 |=>
        fault_flag_bar == ($past(fault_events) == 6'h00))
        else $error("fault pin does not follow fault events");
    select_gap_a: assert property ($rose(serial_select_bar) |->
        serial_select_bar [*8] ##1 serial_select_bar [*4])
        else $error("select high time too short");
    quiet_write_a: assert property (cfg_mode_write |->
        phase_high_side_input == 3'h0 && phase_low_side_input == 3'h0)
        else $error("phase inputs active at mode write");
    ready_wait_a: assert property (!serial_select_bar |-> up_q >= READY_CYC)
        else $error("frame before serial port ready");
    mode_write_a: assert property (cfg_mode_write && !serial_select_bar |=>
        active_mode == ($past(cfg_mode_value) == 2'h3 ? MODE_GEN :
        ($past(cfg_mode_value) == 2'h2 ? MODE_3IN : MODE_6IN)))
        else $error("mode write not applied");
endmodule
